/* File: rtl/dfo_deframer.sv */
`timescale 1ns/100ps
`default_nettype none
module dfo_deframer #(
  parameter int PCNT_W = 12
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire dfo_pkg::dfo_aux_type aux_ch_i,
  input  wire dfo_pkg::dfo_bch_type b_ch_i,
  input  wire logic                 sync_mode_i,
  dfo_link_if.rx                    link,
  output logic                      locked_o,
  output logic                      crc_err_o,
  output logic                      frame_vld_o,
  output dfo_pkg::dfo_eoc_type      eoc_o,
  output logic                      far_losd_o,
  output logic                      far_sega_o,
  output logic                      far_segd_o,
  output logic                      far_pwr_o,
  output logic                      stuffed_o,
  output logic                      pl_data_o,
  output logic                      pl_vld_o
);
  import dfo_pkg::*;

  if (PCNT_W < 12)
    $error("PCNT_W too small for largest payload group");

  typedef struct packed {
    dfo_rx_st_type     st;
    logic [5:0]        idx;
    logic [PCNT_W-1:0] pcnt;
    logic [PCNT_W-1:0] blk;
    dfo_img_type       img;
    logic [13:0]       sh;
    logic              sync;
    logic              locked;
    logic              first;
    dfo_crc_type       calc_prev;
    logic              crc_err;
    logic              frame_vld;
    dfo_eoc_type       eoc;
    logic [3:0]        far;
    logic              stuffed;
    logic              pl_data;
    logic              pl_vld;
  } dfo_rxs_type;

  dfo_rxs_type s_r;
  dfo_rxs_type s_nxt;
  dfo_crc_type crc_val;
  dfo_crc_type rx_crc;
  logic        crc_en;
  logic        crc_clr;
  logic        b;
  logic        stuffed;

  // ----------------------------------------------------------------
  // Frame hunt and field extraction
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt           = s_r;
    crc_en          = 1'b0;
    crc_clr         = 1'b0;
    b               = link.line_bit;
    stuffed         = s_r.img[OH_SBID1] & s_r.img[OH_SBID2] & ~s_r.sync;
    for (int j = 0; j < 6; j++)
      rx_crc[5-j] = s_r.img[CRC_POS[j]];
    if (ce_i)
    begin
      // Pulses clear only while enabled, so a freeze holds them
      s_nxt.pl_vld    = 1'b0;
      s_nxt.frame_vld = 1'b0;
      case (s_r.st)
        RX_HUNT:
          if (link.line_vld)
          begin
            s_nxt.sh = {s_r.sh[12:0], b};
            if ({s_r.sh[12:0], b} == ALIGN_WORD)
            begin
              s_nxt.st     = RX_OH;
              s_nxt.idx    = OH_LOSD;
              s_nxt.pcnt   = '0;
              s_nxt.locked = 1'b1;
              s_nxt.first  = 1'b1;
              s_nxt.sync   = sync_mode_i;
              s_nxt.blk    = PCNT_W'(k_f(aux_ch_i, b_ch_i)) * PCNT_W'(BLK_PER_GRP);
              crc_clr      = 1'b1;
            end
          end
        RX_OH:
          if (link.line_vld)
          begin
            s_nxt.img[s_r.idx] = b;
            crc_en = in_crc_f(s_r.idx, 1'b0, s_r.sync);
            if (s_r.idx <= ALIGN_LEN && b != ALIGN_WORD[4'(ALIGN_LEN - s_r.idx)])
            begin
              s_nxt.st     = RX_HUNT;
              s_nxt.locked = 1'b0;
              s_nxt.sh     = '0;
            end
            else if (grp_end_f(s_r.idx))
              s_nxt.st = RX_PL;
            else
              s_nxt.idx = s_r.idx + 6'h01;
          end
        RX_PL:
          if (link.line_vld)
          begin
            s_nxt.pl_data = b;
            s_nxt.pl_vld  = 1'b1;
            crc_en        = 1'b1;
            s_nxt.pcnt    = s_r.pcnt + 1'b1;
            if (s_r.pcnt == s_r.blk - 1'b1)
            begin
              s_nxt.pcnt = '0;
              s_nxt.idx  = s_r.idx + 6'h01;
              if (s_r.idx != OH_LAST)
                s_nxt.st = RX_OH;
              else if (s_r.sync || stuffed)
                s_nxt.st = RX_TAIL;
              else
                s_nxt.st = RX_END;
            end
          end
        RX_TAIL:
          if (link.line_vld)
          begin
            s_nxt.img[s_r.idx] = b;
            crc_en = in_crc_f(s_r.idx, 1'b1, s_r.sync);
            if (s_r.idx == (s_r.sync ? OH_SYNC_END : OH_STUF_END))
              s_nxt.st = RX_END;
            else
              s_nxt.idx = s_r.idx + 6'h01;
          end
        RX_END:
        begin
          // compare with previous frame, skip first
          s_nxt.crc_err   = ~s_r.first & (rx_crc != s_r.calc_prev);
          s_nxt.calc_prev = crc_val;
          s_nxt.first     = 1'b0;
          s_nxt.frame_vld = 1'b1;
          for (int j = 0; j < 20; j++)
            s_nxt.eoc[j] = s_r.img[EOC_POS[j]];
          s_nxt.far     = {s_r.img[OH_LOSD], s_r.img[OH_SEGA],
                           s_r.img[OH_SEGD], s_r.img[OH_PWR]};
          s_nxt.stuffed = stuffed;
          s_nxt.st      = RX_OH;
          s_nxt.idx     = OH_FIRST;
          s_nxt.sync    = sync_mode_i;
          s_nxt.blk     = PCNT_W'(k_f(aux_ch_i, b_ch_i)) * PCNT_W'(BLK_PER_GRP);
          crc_clr       = 1'b1;
        end
        default:
          s_nxt.st = RX_HUNT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_r     <= '0;
      s_r.st  <= RX_HUNT;
      s_r.far <= 4'hF;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Check engine and outputs
  // ----------------------------------------------------------------
  dfo_crc6 i_dfo_crc6 (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .clr_i     (crc_clr),
    .en_i      (crc_en),
    .bit_i     (b),
    .crc_o     (crc_val)
  );

  assign locked_o    = s_r.locked;
  assign crc_err_o   = s_r.crc_err;
  assign frame_vld_o = s_r.frame_vld;
  assign eoc_o       = s_r.eoc;
  assign far_losd_o  = s_r.far[3];
  assign far_sega_o  = s_r.far[2];
  assign far_segd_o  = s_r.far[1];
  assign far_pwr_o   = s_r.far[0];
  assign stuffed_o   = s_r.stuffed;
  assign pl_data_o   = s_r.pl_data;
  assign pl_vld_o    = s_r.pl_vld;
endmodule : dfo_deframer
`default_nettype wire

/* File: inc/dfo_pkg.sv */
`default_nettype none
package dfo_pkg;
  localparam logic [13:0] ALIGN_WORD  = 14'h3F0C;
  localparam logic [5:0]  ALIGN_LEN   = 6'h0E;
  localparam logic [5:0]  CRC_POLY    = 6'h03;
  localparam logic [5:0]  OH_FIRST    = 6'h01;
  localparam logic [5:0]  OH_LOSD     = 6'h0F;
  localparam logic [5:0]  OH_SEGA     = 6'h10;
  localparam logic [5:0]  OH_PWR      = 6'h17;
  localparam logic [5:0]  OH_SBID1    = 6'h18;
  localparam logic [5:0]  OH_SEGD     = 6'h21;
  localparam logic [5:0]  OH_SBID2    = 6'h24;
  localparam logic [5:0]  OH_LAST     = 6'h2E;
  localparam logic [5:0]  OH_TAIL     = 6'h2F;
  localparam logic [5:0]  OH_SYNC_END = 6'h30;
  localparam logic [5:0]  OH_STUF_END = 6'h32;
  localparam logic [3:0]  BLK_PER_GRP = 4'hC;
  localparam logic [19:0][5:0] EOC_POS = {
    6'h2E, 6'h2D, 6'h2C, 6'h2B, 6'h28, 6'h27, 6'h26, 6'h25, 6'h23, 6'h22,
    6'h1E, 6'h1D, 6'h1C, 6'h1B, 6'h1A, 6'h19, 6'h14, 6'h13, 6'h12, 6'h11};
  localparam logic [5:0][5:0] CRC_POS = {
    6'h2A, 6'h29, 6'h20, 6'h1F, 6'h16, 6'h15};
  localparam logic [5:0][5:0] GRP_END = {
    6'h2E, 6'h2E, 6'h24, 6'h1A, 6'h10, 6'h10};

  typedef logic [19:0] dfo_eoc_type;
  typedef logic [2:0]  dfo_aux_type;
  typedef logic [5:0]  dfo_bch_type;
  typedef logic [5:0]  dfo_crc_type;
  typedef logic [50:0] dfo_img_type;
  typedef enum logic [1:0] {TX_LOAD, TX_OH, TX_PL, TX_TAIL} dfo_tx_st_type;
  typedef enum logic [2:0] {RX_HUNT, RX_OH, RX_PL, RX_TAIL, RX_END} dfo_rx_st_type;

  function automatic logic [8:0] k_f(input dfo_aux_type aux, input dfo_bch_type bch);
    return 9'(aux) + {bch, 3'b000};
  endfunction : k_f

  function automatic logic grp_end_f(input logic [5:0] idx);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j < 6; j++)
      hit = hit | (idx == GRP_END[j]);
    return hit;
  endfunction : grp_end_f

  // check input excludes word, check and stuff bits
  function automatic logic in_crc_f(input logic [5:0] idx, input logic tail, input logic sync);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j < 6; j++)
      hit = hit | (idx == CRC_POS[j]);
    return tail ? sync : ((idx > ALIGN_LEN) && !hit);
  endfunction : in_crc_f
endpackage : dfo_pkg
`default_nettype wire

/* File: inc/dfo_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dfo_link_if;
  logic line_bit;
  logic line_vld;
  modport tx (output line_bit, output line_vld);
  modport rx (input line_bit, input line_vld);
endinterface : dfo_link_if
`default_nettype wire

/* File: rtl/dfo_crc6.sv */
`timescale 1ns/100ps
`default_nettype none
module dfo_crc6 (
  input  wire logic            ref_clk_i,
  input  wire logic            sys_rst_i,
  input  wire logic            ce_i,
  input  wire logic            clr_i,
  input  wire logic            en_i,
  input  wire logic            bit_i,
  output var  dfo_pkg::dfo_crc_type crc_o
);
  import dfo_pkg::*;

  typedef struct packed {
    dfo_crc_type rem;
  } dfo_crc_st_type;

  dfo_crc_st_type s_r;
  dfo_crc_st_type s_nxt;
  logic           fb;

  always_comb
  begin
    s_nxt = s_r;
    fb    = bit_i ^ s_r.rem[5];
    if (ce_i)
    begin
      if (clr_i)
        s_nxt.rem = '0;
      // divide by X^6 + X + 1
      else if (en_i)
        s_nxt.rem = {s_r.rem[4:0], 1'b0} ^ ({6{fb}} & CRC_POLY);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign crc_o = s_r.rem;
endmodule : dfo_crc6
`default_nettype wire

/* File: rtl/dfo_framer.sv */
`timescale 1ns/100ps
`default_nettype none
module dfo_framer #(
  parameter int PCNT_W = 12
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 bit_tick_i,
  input  wire dfo_pkg::dfo_aux_type aux_ch_i,
  input  wire dfo_pkg::dfo_bch_type b_ch_i,
  input  wire logic                 sync_mode_i,
  input  wire logic                 stuff_req_i,
  input  wire logic                 sig_present_i,
  input  wire logic                 crc_err_i,
  input  wire logic                 sync_loss_i,
  input  wire logic                 is_remote_i,
  input  wire logic                 regen_i,
  input  wire logic                 power_ok_i,
  input  wire logic                 pwr_fwd_i,
  input  wire dfo_pkg::dfo_eoc_type eoc_i,
  output logic                      eoc_take_o,
  input  wire logic                 pl_data_i,
  output logic                      pl_take_o,
  dfo_link_if.tx                    link
);
  import dfo_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (PCNT_W < 12)
    $error("PCNT_W too small for largest payload group");

  // Whole framer state, registered in one place
  typedef struct packed {
    dfo_tx_st_type     st;
    logic [5:0]        idx;
    logic [PCNT_W-1:0] pcnt;
    logic [PCNT_W-1:0] blk;
    dfo_img_type       img;
    logic              sync;
    logic              lb;
    logic              vld;
  } dfo_txs_type;

  dfo_txs_type s_r;
  dfo_txs_type s_nxt;
  dfo_img_type img_new;
  dfo_crc_type crc_val;
  logic        load;
  logic        crc_en;
  logic        tx_bit;
  logic        stuffed;

  // ----------------------------------------------------------------
  // Overhead image of the next frame
  // ----------------------------------------------------------------
  always_comb
  begin
    // Image is rebuilt every cycle and latched only at load
    // unassigned bits one
    img_new = '1;
    for (int i = 0; i < 14; i++)
      img_new[i+1] = ALIGN_WORD[13-i];
    img_new[OH_LOSD] = sig_present_i;
    img_new[OH_SEGA] = ~crc_err_i;
    img_new[OH_SEGD] = ~sync_loss_i;
    if (regen_i)
      img_new[OH_PWR] = pwr_fwd_i;
    else if (is_remote_i)
      img_new[OH_PWR] = power_ok_i;
    img_new[OH_SBID1] = sync_mode_i | stuff_req_i;
    img_new[OH_SBID2] = sync_mode_i | stuff_req_i;
    for (int j = 0; j < 20; j++)
      img_new[EOC_POS[j]] = eoc_i[j];
    // previous frame check, first one zero
    for (int j = 0; j < 6; j++)
      img_new[CRC_POS[j]] = crc_val[5-j];
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt     = s_r;
    load      = 1'b0;
    crc_en    = 1'b0;
    tx_bit    = 1'b1;
    // Tail length follows the indicator latched at load
    stuffed   = s_r.img[OH_SBID1] & ~s_r.sync;
    if (ce_i)
    begin
      // Pulse clears only while enabled, so a freeze holds it
      s_nxt.vld = 1'b0;
      // Load cycle takes no tick, so each frame restarts cleanly
      if (bit_tick_i && s_r.st != TX_LOAD)
        s_nxt.vld = 1'b1;
      case (s_r.st)
        TX_LOAD:
          load = 1'b1;
        TX_OH:
          if (bit_tick_i)
          begin
            tx_bit = s_r.img[s_r.idx];
            crc_en = in_crc_f(s_r.idx, 1'b0, s_r.sync);
            if (grp_end_f(s_r.idx))
              s_nxt.st = TX_PL;
            else
              s_nxt.idx = s_r.idx + 6'h01;
          end
        TX_PL:
          if (bit_tick_i)
          begin
            tx_bit = pl_data_i;
            crc_en = 1'b1;
            s_nxt.pcnt = s_r.pcnt + 1'b1;
            if (s_r.pcnt == s_r.blk - 1'b1)
            begin
              s_nxt.pcnt = '0;
              s_nxt.idx  = s_r.idx + 6'h01;
              if (s_r.idx != OH_LAST)
                s_nxt.st = TX_OH;
              // tail of four, two or none
              else if (s_r.sync || stuffed)
                s_nxt.st = TX_TAIL;
              else
                s_nxt.st = TX_LOAD;
            end
          end
        // Four stuff or two spare bits; only the spare bits enter the check
        TX_TAIL:
          if (bit_tick_i)
          begin
            // stuff and spare bits are one
            tx_bit = s_r.img[s_r.idx];
            crc_en = in_crc_f(s_r.idx, 1'b1, s_r.sync);
            if (s_r.idx == (s_r.sync ? OH_SYNC_END : OH_STUF_END))
              s_nxt.st = TX_LOAD;
            else
              s_nxt.idx = s_r.idx + 6'h01;
          end
        default:
          s_nxt.st = TX_LOAD;
      endcase
      // Line bit holds between pulses
      if (s_nxt.vld)
        s_nxt.lb = tx_bit;
      if (load)
      begin
        // Channel counts and modes are sampled once per frame
        s_nxt.img  = img_new;
        s_nxt.st   = TX_OH;
        s_nxt.idx  = OH_FIRST;
        s_nxt.pcnt = '0;
        s_nxt.sync = sync_mode_i;
        s_nxt.blk  = PCNT_W'(k_f(aux_ch_i, b_ch_i)) * PCNT_W'(BLK_PER_GRP);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      s_r    <= '0;
      s_r.st <= TX_LOAD;
      s_r.lb <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Check engine and outputs
  // ----------------------------------------------------------------
  // Engine clears at load, after its remainder went into the image
  dfo_crc6 i_dfo_crc6 (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .clr_i     (load),
    .en_i      (crc_en),
    .bit_i     (tx_bit),
    .crc_o     (crc_val)
  );

  // Frame fields are taken in the load cycle only
  assign eoc_take_o    = load;
  // Payload source presents its bit in the same cycle
  assign pl_take_o     = ce_i & bit_tick_i & (s_r.st == TX_PL);
  assign link.line_bit = s_r.lb;
  assign link.line_vld = s_r.vld;
endmodule : dfo_framer
`default_nettype wire

/* File: tb/dfo_link_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module dfo_link_asserts #(
  parameter int K = 8
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic line_bit,
  input wire logic line_vld,
  input wire logic sync_mode_i,
  input wire logic stuff_req_i
);
  localparam logic [13:0] ALIGN = 14'h3F0C;
  localparam int          BODY  = 48 * K + 46;
  logic [11:0] pos_r;
  logic [5:0]  run_r;
  logic [5:0]  prev_r;
  logic        first_r;
  logic [2:0]  crc_idx;
  logic        incl;
  logic [5:0]  stepped;
  int          flen;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------
  // Bit position and running check of frame
  // ----------------------------------------
  always_comb
  begin
    flen = sync_mode_i ? BODY + 2 : (stuff_req_i ? BODY + 4 : BODY);
    crc_idx = 3'h0;
    for (int j = 0; j < 3; j++)
    begin
      if (int'(pos_r) == 12 * K * (j + 1) + 10 * j + 21) crc_idx = 3'(2 * j + 1);
      if (int'(pos_r) == 12 * K * (j + 1) + 10 * j + 22) crc_idx = 3'(2 * j + 2);
    end
    incl = (pos_r > 12'h00E) && (crc_idx == 3'h0) && (int'(pos_r) <= BODY || sync_mode_i);
    stepped = incl ? ({run_r[4:0], 1'b0} ^ ((run_r[5] ^ line_bit) ? 6'h03 : 6'h00)) : run_r;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pos_r   <= 12'h001;
      run_r   <= 6'h00;
      prev_r  <= 6'h00;
      first_r <= 1'b1;
    end
    else if (line_vld)
    begin
      run_r <= stepped;
      pos_r <= pos_r + 12'h001;
      if (int'(pos_r) == flen)
      begin
        pos_r   <= 12'h001;
        run_r   <= 6'h00;
        prev_r  <= stepped;
        first_r <= 1'b0;
      end
    end
  end

  a_align_word:
  assert property (line_vld && pos_r <= 12'h00E |-> line_bit == ALIGN[4'(14 - int'(pos_r))])
    else $error("alignment word bit wrong");
  a_tail_spare:
  assert property (line_vld && sync_mode_i && int'(pos_r) > BODY |-> line_bit)
    else $error("spare tail bit not one");
  a_tail_stuff:
  assert property (line_vld && !sync_mode_i && int'(pos_r) > BODY |-> line_bit)
    else $error("stuff bit not one");
  a_sbid_first:
  assert property (line_vld && int'(pos_r) == 12 * K + 24 |-> line_bit == (sync_mode_i || stuff_req_i))
    else $error("first stuff indicator wrong");
  a_sbid_second:
  assert property (line_vld && int'(pos_r) == 24 * K + 36 |-> line_bit == (sync_mode_i || stuff_req_i))
    else $error("second stuff indicator wrong");
  a_crc_first:
  assert property (line_vld && first_r && crc_idx != 3'h0 |-> !line_bit)
    else $error("first frame check bit not zero");
  a_crc_match:
  assert property (line_vld && !first_r && crc_idx != 3'h0 |-> line_bit == prev_r[3'h6 - crc_idx])
    else $error("check bit differs from previous frame remainder");
  a_line_pulse:
  assert property (line_vld |=> !line_vld)
    else $error("line valid longer than one cycle");

  c_sync_end: cover property (line_vld && sync_mode_i && int'(pos_r) == BODY + 2);
  c_stuff_end: cover property (line_vld && int'(pos_r) == BODY + 4);
  c_crc_seen: cover property (line_vld && !first_r && crc_idx == 3'h6);
endmodule : dfo_link_asserts
`default_nettype wire

/* File: tb/dsl_frame_overhead_crc6_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("FAIL t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module dsl_frame_overhead_crc6_test;
  import dfo_pkg::*;
  localparam int          K = 10;
  localparam logic [10:0] CASES [8] = '{11'h4AF, 11'h0A7, 11'h6AB, 11'h5AD,
                                        11'h48E, 11'h46E, 11'h45F, 11'h40F};
  logic        ref_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic        ce        = 1'b1;
  logic        tick      = 1'b0;
  logic        sync_md   = 1'b1;
  logic        stuf_rq   = 1'b0;
  logic [6:0]  ctl       = 7'h4A;
  dfo_aux_type aux       = 3'h2;
  dfo_bch_type bch       = 6'h01;
  dfo_eoc_type eoc       = '0;
  logic        pl_bit    = 1'b0;
  logic        pl_take, locked, crc_err, f_vld, losd, sega, segd, pwr, stuffed, pl_vld;
  logic        pl_data, eoc_take;
  logic        pl_prev   = 1'b1;
  dfo_eoc_type eoc_rx;
  int          err_total = 0;
  int          tests_run = 0;
  int          pl_run    = 0;
  int          pl_last   = 0;
  int          pl_bad    = 0;
  int          bad_last  = 0;
  int          take_run  = 0;
  int          take_last = 0;
  dfo_link_if  link ();

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tick <= sys_rst ? 1'b0 : ~tick;
  always @(posedge ref_clk) if (pl_take) pl_bit <= ~pl_bit;
  always @(posedge ref_clk)
  begin
    if (ce)
    begin
      if (pl_vld)
      begin
        pl_prev <= pl_data;
        pl_run  <= pl_run + 1;
        if (pl_data === pl_prev)
          pl_bad <= pl_bad + 1;
      end
      if (eoc_take)
        take_run <= take_run + 1;
      if (f_vld)
      begin
        pl_last   <= pl_run;
        pl_run    <= 0;
        bad_last  <= pl_bad;
        pl_bad    <= 0;
        take_last <= take_run;
        take_run  <= 0;
      end
    end
  end

  dfo_framer #(.PCNT_W(12)) i_dfo_framer (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(ce), .bit_tick_i(tick),
    .aux_ch_i(aux), .b_ch_i(bch), .sync_mode_i(sync_md), .stuff_req_i(stuf_rq),
    .sig_present_i(ctl[6]), .crc_err_i(ctl[5]), .sync_loss_i(ctl[4]), .is_remote_i(ctl[3]),
    .regen_i(ctl[2]), .power_ok_i(ctl[1]), .pwr_fwd_i(ctl[0]), .eoc_i(eoc),
    .eoc_take_o(eoc_take),
    .pl_data_i(pl_bit), .pl_take_o(pl_take), .link(link.tx));
  dfo_deframer #(.PCNT_W(12)) i_dfo_deframer (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(ce), .aux_ch_i(aux), .b_ch_i(bch),
    .sync_mode_i(sync_md), .link(link.rx), .locked_o(locked), .crc_err_o(crc_err),
    .frame_vld_o(f_vld), .eoc_o(eoc_rx), .far_losd_o(losd), .far_sega_o(sega),
    .far_segd_o(segd), .far_pwr_o(pwr), .stuffed_o(stuffed), .pl_data_o(pl_data),
    .pl_vld_o(pl_vld));
  dfo_link_asserts #(.K(K)) i_dfo_link_asserts (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .line_bit(link.line_bit),
    .line_vld(link.line_vld & ce), .sync_mode_i(sync_md), .stuff_req_i(stuf_rq));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic restart(input logic sm, input logic sr);
    sys_rst <= 1'b1;
    sync_md <= sm;
    stuf_rq <= sr;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : restart

  task automatic wait_frame;
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while ((f_vld & ce) !== 1'b1 && n < 3000);
    if (n >= 3000) `CHK(n, 0)
  endtask : wait_frame

  // --------------------------------------------
  // Read two frames, judge the second at its end
  // --------------------------------------------
  task automatic read_check(input logic [3:0] exp);
    wait_frame();
    wait_frame();
    #1;
    `CHK(locked, 1'b1)
    `CHK(crc_err, 1'b0)
    `CHK(eoc_rx, eoc)
    `CHK(pl_last, 48 * K)
    `CHK(bad_last, 0)
    `CHK(take_last, 1)
    `CHK(losd, exp[3])
    `CHK(sega, exp[2])
    `CHK(segd, exp[1])
    `CHK(pwr, exp[0])
    @(posedge ref_clk);
  endtask : read_check

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end

  initial
  begin
    restart(1'b1, 1'b0);
    for (int c = 0; c < 8; c++)
    begin
      ctl <= CASES[c][10:4];
      eoc <= 20'h5A3C9 ^ (20'h0F0F1 << c);
      // Even-length freeze mid-frame, which the next frame's check must pass unflagged
      if (c == 4)
      begin
        repeat (301) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (8) @(posedge ref_clk);
        ce <= 1'b1;
      end
      read_check(CASES[c][3:0]);
    end
    for (int s = 1; s >= 0; s--)
    begin
      ctl <= 7'h4A;
      restart(1'b0, s[0]);
      read_check(4'hF);
      `CHK(stuffed, s[0])
    end
    report_and_stop();
  end
endmodule : dsl_frame_overhead_crc6_test
`default_nettype wire
